// ===== distributed_strobe_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module distributed_strobe_fifo #(
    parameter int                          DEPTH      =
        strobe_fifo_pkg::DEPTH_DEFAULT,
    parameter int                          WIDTH      =
        strobe_fifo_pkg::WIDTH_DEFAULT,
    parameter strobe_fifo_pkg::write_edge_t WRITE_EDGE =
        strobe_fifo_pkg::WRITE_EDGE_DEFAULT
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // User strobes, asynchronous to clk_i
    input  wire logic             write_strobe_i,
    input  wire logic             read_strobe_i,
    input  wire logic             init_i,
    // Data
    input  wire logic [WIDTH-1:0] write_data_bits_i,
    output var  logic [WIDTH-1:0] read_data_bits_o,
    // Occupancy
    output var  logic             empty_o,
    output var  logic             full_o
);

    // Latency: a strobe edge at the pin is acted on at the third clock
    // edge after it, and the flags and read word change at that edge.
    // Strobe levels shorter than two clocks may be missed altogether,
    // which is the price of taking the strobes through synchronisers.

    // Pointer and counter widths follow the configured depth.
    localparam int            PW      = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int            CW      = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_C  = PW'(DEPTH - 1);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    // The strobes and init come from user logic on another timing, so
    // each passes two flops before any decision is made on it. A third
    // flop of each strobe keeps the previous settled level for edge
    // detection. The data word takes the same two-stage path so that it
    // lines up with the detected strobe edge; the user must therefore
    // hold the word steady for a few clocks on both sides of the edge.
    logic [2:0]       wr_sync_reg;
    logic [2:0]       wr_sync_next;
    logic [2:0]       rd_sync_reg;
    logic [2:0]       rd_sync_next;
    logic [1:0]       init_sync_reg;
    logic [1:0]       init_sync_next;
    logic [WIDTH-1:0] data_s1_reg;
    logic [WIDTH-1:0] data_s1_next;
    logic [WIDTH-1:0] data_s2_reg;
    logic [WIDTH-1:0] data_s2_next;

    always_comb begin
        wr_sync_next   = {wr_sync_reg[1:0], write_strobe_i};
        rd_sync_next   = {rd_sync_reg[1:0], read_strobe_i};
        init_sync_next = {init_sync_reg[0], init_i};
        data_s1_next   = write_data_bits_i;
        data_s2_next   = data_s1_reg;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_sync_reg   <= 3'h0;
            rd_sync_reg   <= 3'h0;
            init_sync_reg <= 2'h0;
            data_s1_reg   <= '0;
            data_s2_reg   <= '0;
        end else begin
            wr_sync_reg   <= wr_sync_next;
            rd_sync_reg   <= rd_sync_next;
            init_sync_reg <= init_sync_next;
            data_s1_reg   <= data_s1_next;
            data_s2_reg   <= data_s2_next;
        end
    end

    // Edges are taken between the second and third flop, so each edge is
    // seen exactly once whatever the strobe width, provided each level
    // lasts at least two clocks. The write edge is picked by the build
    // option: rising for WRITE_EDGE_RISE, falling for WRITE_EDGE_FALL.
    logic wr_edge;
    logic rd_edge;
    logic init_lvl;

    always_comb begin
        if (WRITE_EDGE == strobe_fifo_pkg::WRITE_EDGE_RISE) begin
            wr_edge = wr_sync_reg[1] & ~wr_sync_reg[2];
        end else begin
            wr_edge = ~wr_sync_reg[1] & wr_sync_reg[2];
        end
    end

    always_comb begin
        rd_edge = rd_sync_reg[1] & ~rd_sync_reg[2];
    end

    // Init acts as a level: while it is seen high the queue stays empty.
    always_comb begin
        init_lvl = init_sync_reg[1];
    end

    // State of the queue. The storage itself is addressed only by the two
    // internal pointers; nothing outside picks a location.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wptr_reg;
    logic [PW-1:0]    wptr_next;
    logic [PW-1:0]    rptr_reg;
    logic [PW-1:0]    rptr_next;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic [WIDTH-1:0] rdata_reg;
    logic [WIDTH-1:0] rdata_next;
    logic [WIDTH-1:0] last_wr_reg;
    logic [WIDTH-1:0] last_wr_next;
    strobe_fifo_pkg::fifo_flags_t flags_reg;
    strobe_fifo_pkg::fifo_flags_t flags_next;
    logic             do_wr;
    logic             do_rd;
    logic             rd_refused;

    // A write is refused while the store is full and a read while it is
    // empty. Init wins over both, so a strobe that overlaps the init pulse
    // cannot leave a stray word behind after the restart.
    always_comb begin
        do_wr      = wr_edge && (count_reg != DEPTH_C) && !init_lvl;
        do_rd      = rd_edge && (count_reg != '0) && !init_lvl;
        rd_refused = rd_edge && (count_reg == '0) && !init_lvl;
    end

    // Both pointers wrap at the last entry rather than at a power of two,
    // so any depth works; init returns them to the first entry.
    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        if (init_lvl) begin
            wptr_next = '0;
            rptr_next = '0;
        end else begin
            if (do_wr) begin
                if (wptr_reg == LAST_C) begin
                    wptr_next = '0;
                end else begin
                    wptr_next = wptr_reg + PTR_ONE;
                end
            end
            if (do_rd) begin
                if (rptr_reg == LAST_C) begin
                    rptr_next = '0;
                end else begin
                    rptr_next = rptr_reg + PTR_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
        end
    end

    // A read and a write taken in the same clock cancel in the count.
    always_comb begin
        count_next = count_reg;
        if (init_lvl) begin
            count_next = '0;
        end else begin
            unique case ({do_wr, do_rd})
                2'b10: begin
                    count_next = count_reg + CNT_ONE;
                end
                2'b01: begin
                    count_next = count_reg - CNT_ONE;
                end
                2'b00, 2'b11: begin
                    count_next = count_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Flags are registered from the next count so they move in the same
    // clock as the store and pointers, never one clock behind them.
    always_comb begin
        if (count_next == '0) begin
            flags_next.empty = 1'b1;
        end else begin
            flags_next.empty = 1'b0;
        end
        if (count_next == DEPTH_C) begin
            flags_next.full = 1'b1;
        end else begin
            flags_next.full = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_reg <= strobe_fifo_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // The output word is not cleared by init: it is simply undefined to
    // the user until the first read after init. A read refused on an empty
    // store shows the most recently written word instead of the old one.
    always_comb begin
        rdata_next   = rdata_reg;
        last_wr_next = last_wr_reg;
        if (do_wr) begin
            last_wr_next = data_s2_reg;
        end
        unique case ({do_rd, rd_refused})
            2'b10: begin
                rdata_next = mem_reg[rptr_reg];
            end
            2'b01: begin
                rdata_next = last_wr_reg;
            end
            default: begin
                rdata_next = rdata_reg;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg   <= '0;
            last_wr_reg <= '0;
        end else begin
            rdata_reg   <= rdata_next;
            last_wr_reg <= last_wr_next;
        end
    end

    // One slice per entry: each word loads only when the write pointer
    // selects it. The store has no reset, as an entry is never read
    // before a write has filled it; leaving it out keeps the slices small.
    generate
        for (genvar e = 0; e < DEPTH; e++) begin : g_entry
            logic             sel;
            logic [WIDTH-1:0] word_next;

            always_comb begin
                sel       = do_wr && (wptr_reg == PW'(e));
                word_next = mem_reg[e];
                if (sel) begin
                    word_next = data_s2_reg;
                end
            end

            always_ff @(posedge clk_i) begin
                mem_reg[e] <= word_next;
            end
        end
    endgenerate

    // Every output is a flop output with no gate after it.
    always_comb begin
        read_data_bits_o = rdata_reg;
        empty_o          = flags_reg.empty;
        full_o           = flags_reg.full;
    end

endmodule : distributed_strobe_fifo

`default_nettype wire

// ===== dsf_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dsf_sva #(parameter int W = 16,
    parameter strobe_fifo_pkg::write_edge_t E =
        strobe_fifo_pkg::WRITE_EDGE_RISE) (
    input wire logic         clk_i,
    input wire logic         reset_n_i,
    input wire logic         write_strobe_i,
    input wire logic         read_strobe_i,
    input wire logic         init_i,
    input wire logic [W-1:0] read_data_bits_o,
    input wire logic         empty_o,
    input wire logic         full_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Previous strobe level, so the write edge follows the build mode.
    logic wr_prev;
    logic wr_act;
    always_ff @(posedge clk_i) wr_prev <= write_strobe_i;
    always_comb wr_act = (E == strobe_fifo_pkg::WRITE_EDGE_RISE) ?
        (write_strobe_i && !wr_prev) : (!write_strobe_i && wr_prev);
    chk_flags_excl: assert property (!(empty_o && full_o))
        else $error("Both flags set");
    chk_init_flags: assert property ($fell(init_i) |-> ##4
        empty_o && !full_o) else $error("Init flags wrong");
    chk_first_write: assert property (wr_act &&
        empty_o |-> ##[2:5] !empty_o) else $error("Empty stuck");
    chk_full_ignore: assert property (wr_act &&
        full_o |-> full_o [*6]) else $error("Full write acted");
    chk_read_frees: assert property ($rose(read_strobe_i) &&
        full_o |-> ##[2:5] !full_o) else $error("Full stuck");
    chk_empty_read: assert property ($rose(read_strobe_i) &&
        empty_o |-> empty_o [*6]) else $error("Empty read acted");
    chk_empty_data: assert property ($rose(read_strobe_i) &&
        empty_o |=> $stable(read_data_bits_o) [*5])
        else $error("Data moved");
    // Six quiet samples cover the worst-case synchroniser delay.
    chk_quiet_hold: assert property ($stable({write_strobe_i,
        read_strobe_i, init_i}) [*6] |-> $stable({empty_o, full_o,
        read_data_bits_o})) else $error("Output moved");
    cover property ($rose(full_o));
    cover property ($rose(read_strobe_i) && empty_o);
    cover property ($fell(init_i));
endmodule : dsf_sva
bind distributed_strobe_fifo dsf_sva #(.W(WIDTH), .E(WRITE_EDGE)) i_sva(.clk_i,
    .reset_n_i, .write_strobe_i, .read_strobe_i, .init_i,
    .read_data_bits_o, .empty_o, .full_o);
`default_nettype wire

// ===== strobe_fifo_pkg.sv
`default_nettype none

package strobe_fifo_pkg;

    localparam int DEPTH_DEFAULT = 16;
    localparam int WIDTH_DEFAULT = 16;

    // Write capture edge selection.
    typedef enum logic {
        WRITE_EDGE_RISE = 1'b0,
        WRITE_EDGE_FALL = 1'b1
    } write_edge_t;

    localparam write_edge_t WRITE_EDGE_DEFAULT = WRITE_EDGE_RISE;

    // Occupancy flags travelling together.
    typedef struct packed {
        logic empty;
        logic full;
    } fifo_flags_t;

    localparam fifo_flags_t FLAGS_RESET = '{empty: 1'b1, full: 1'b0};

endpackage : strobe_fifo_pkg

`default_nettype wire

// ===== strobe_user.sv
`timescale 1ns/100ps
`default_nettype none
module strobe_user #(parameter int W = 16) (
    input  wire logic         clk_i,
    output var  logic [2:0]   st_o,
    output var  logic [W-1:0] data_o
);
    initial st_o = 3'h0;
    initial data_o = '0;
    // Bit 0 writes, 1 reads, 2 inits. Data is inverted once its hold
    // has run out, so a stale word can never pass as a fresh one.
    task automatic op(input logic [2:0] s, input logic [W-1:0] d);
        data_o = d;
        repeat (4) @(negedge clk_i);
        st_o = s;
        repeat (4) @(negedge clk_i);
        st_o = 3'h0;
        repeat (3) @(negedge clk_i);
        data_o = ~d;
        @(negedge clk_i);
    endtask : op
endmodule : strobe_user
`default_nettype wire

// ===== tb_distributed_strobe_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module tb_distributed_strobe_fifo;
    localparam int D = 4;
    localparam int W = 16;
    logic [2:0]   st;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         empty, full;
    logic         empty_f, full_f;
    logic [W-1:0] rd_f;
    logic [W-1:0] wd, rd, last, q[$];
    int           num_errors = 0;
    int           tests_run = 0;
    int           seed = 65265;
    initial forever #4 clk = ~clk;
    strobe_user #(.W(W)) i_user(.clk_i(clk), .st_o(st), .data_o(wd));
    distributed_strobe_fifo #(.DEPTH(D), .WIDTH(W)) i_dut(.clk_i(clk),
        .reset_n_i(rst_n), .write_strobe_i(st[0]), .read_strobe_i(st[1]),
        .init_i(st[2]), .write_data_bits_i(wd), .read_data_bits_o(rd),
        .empty_o(empty), .full_o(full));
    distributed_strobe_fifo #(.DEPTH(D), .WIDTH(W),
        .WRITE_EDGE(strobe_fifo_pkg::WRITE_EDGE_FALL)) i_dut_fall(
        .clk_i(clk), .reset_n_i(rst_n), .write_strobe_i(st[0]),
        .read_strobe_i(st[1]), .init_i(st[2]), .write_data_bits_i(wd),
        .read_data_bits_o(rd_f), .empty_o(empty_f), .full_o(full_f));
    function automatic logic [W-1:0] flags(input int n);
        return {n == 0, n == D};
    endfunction : flags
    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] ex);
        tests_run++;
        if (seen !== ex) begin
            num_errors++;
            $display("Error at %0t: saw %h, want %h", $time, seen, ex);
        end
    endtask : check
    task automatic xfer(input logic [2:0] s, input logic [W-1:0] d);
        i_user.op(s, d);
        if (s[2]) q.delete();
        else if (s[0] && q.size() < D) q.push_back(d);
        else if (s[1] && q.size() > 0) last = q.pop_front();
        if (s[1]) check(rd, last);
        check({empty, full}, flags(q.size()));
        if (s[1]) check(rd_f, last);
        check({empty_f, full_f}, flags(q.size()));
    endtask : xfer
    task automatic end_of_test;
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        xfer(3'h4, '0);
        // The last write of this burst lands on a full store.
        repeat (D + 1) xfer(3'h1, W'($random(seed)));
        xfer(3'h2, '0);
        xfer(3'h1, 16'hffff);
        repeat (D + 1) xfer(3'h2, '0);
        xfer(3'h1, '0);
        xfer(3'h4, '0);
        xfer(3'h1, W'($random(seed)));
        xfer(3'h2, '0);
        end_of_test();
    end
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule : tb_distributed_strobe_fifo
`default_nettype wire
